// ### inc/front_panel_pkg.sv
/*
  Constants shared by the front-panel control block: register map, field
  positions, lamp and switch bit positions, fault code table and timing.
  Assumes a 200 MHz hclk and a 32-bit AHB-Lite register bus.
*/
package front_panel_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] CODE_OFF = 8'h08;
	localparam logic [7:0] HIDX_OFF = 8'h0c;
	localparam logic [7:0] HDAT_OFF = 8'h10;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// control field positions
	localparam int CTRL_LLOCK = 0;
	localparam int CTRL_DDIS  = 1;
	localparam int CTRL_SPIN  = 2;
	// status field positions
	localparam int ST_FAULT = 0;
	localparam int ST_SHOW  = 1;
	localparam int ST_TEST  = 2;
	localparam int ST_SPIN  = 3;
	localparam int ST_ARMED = 4;
	localparam int ST_LAMP  = 8;
	localparam int HIDX_CNT = 8;
	// lamp bit = weight of that lamp in the logged code; error lamp fills bit 1
	localparam int L_READY = 0;
	localparam int L_ERR   = 1;
	localparam int L_A     = 2;
	localparam int L_B     = 3;
	localparam int L_LOCK  = 4;
	localparam int L_SPIN  = 5;
	localparam logic [5:0] LAMPS_ALL   = 6'h3f;
	localparam logic [5:0] LAMPS_DCLOW = 6'h3d;
	localparam logic [5:0] LAMPS_OFF   = 6'h00;
	// synchronised switch positions
	localparam int SW_RUN = 0;
	localparam int SW_ERR = 1;
	localparam int SW_WL  = 2;
	localparam int SW_PA  = 3;
	localparam int SW_PB  = 4;
	localparam int NUM_SW = 5;
	// fault causes, lowest index most severe; last two raised internally
	localparam int NUM_EXT    = 15;
	localparam int NUM_CAUSES = 17;
	localparam logic [5:0] CAUSE_CODE [NUM_CAUSES] = '{
		6'h10, 6'h18, 6'h14, 6'h08, 6'h1c, 6'h0d, 6'h01, 6'h09, 6'h05,
		6'h20, 6'h28, 6'h30, 6'h38, 6'h34, 6'h3d, 6'h24, 6'h2c};
	localparam int HIST_DEPTH = 16;
	// blink half period
	localparam longint BLINK_HALF_NS = 250000000;
	localparam longint CLK_PERIOD_NS = 5;
	localparam int unsigned BLINK_HALF_CYC = int'(BLINK_HALF_NS / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		P_NORMAL = 2'b00,
		P_SHOW   = 2'b01,
		P_TEST   = 2'b10
	} panel_e;
endpackage

// ### src/history_silo.sv
/*
  Sixteen-entry store for specific fault codes, one write port and one
  registered read port. Assumes the caller wraps the write address.
*/
`timescale 1ns/1ps
module history_silo
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       we,
	input  wire logic [3:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [3:0] raddr,
	output logic      [7:0] rdata_q
);
	logic [7:0] mem [16];

	// storage needs no reset; contents are only meaningful below the count
	always_ff @(posedge hclk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// registered read port
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata_q <= 8'h00;
		else
			rdata_q <= mem[raddr];
	end
endmodule

// ### src/drive_front_panel_control.sv
/*
  Front-panel control of a dual-ported disk drive: lamps, spindle switch,
  error button sequencing, fault code display, history and status byte 15.
  Assumes drive status inputs are on hclk; panel switches are asynchronous
  pins. Registers reached over AHB-Lite, zero wait states.
*/
// Our own choices: the placing of the registers and the AHB-Lite slave port.
// Functional notes
// RL1: spindle lamp follows spindle rotation only
// RL2: ready lamp needs spindle, on cylinder, serviceable
// RL3: error lamp tracks detected fault
// RL4: lock lamp on for switch or logical lock
// RL5: port lamp lit while online to that port
// RL6: run requests spin-up, stop retracts and stops
// RL7: run at power-up waits command or toggle
// RL8: stop waits for outstanding controller operations
// RL9: starter leaves three minutes between starts; this block has no start lockout
// RL10: self-corrected faults clear lamp, others hold
// RL11: first press goes offline, blinks fault code
// RL12: second press clears, restores lamps, available
// RL13: display shows most recent fault code only
// RL14: cleared codes kept in sixteen-entry history
// RL15: general fault code reported in status byte
// RL16: held button after self-test lights all lamps
// RL17: positioning and master faults use 10,18,14
// RL18: spindle 08, motor interlock 1C, servo 0D
// RL19: overtemp 01, unsafe 09, command fault 05
// RL20: index fault 20, bad servo write 28
// RL21: disabled drive 24, locked write 2C
// RL22: low supply lights all but error, unlogged
// RL23: shown lamps are code bits plus error
`timescale 1ns/1ps
module drive_front_panel_control
#(
	parameter int unsigned BLINK_CYC = front_panel_pkg::BLINK_HALF_CYC
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        run_switch_pin,
	input  wire logic        error_button_pin,
	input  wire logic        write_lock_switch,
	input  wire logic        port_a_switch_pin,
	input  wire logic        port_b_switch_pin,
	input  wire logic        spindle_turning,
	input  wire logic        on_cylinder,
	input  wire logic        seeking,
	input  wire logic        host_ready,
	input  wire logic        post_done,
	input  wire logic        ctrl_access_a,
	input  wire logic        ctrl_access_b,
	input  wire logic        ops_pending,
	input  wire logic        dc_low,
	input  wire logic        write_attempt,
	input  wire logic [front_panel_pkg::NUM_EXT-1:0] fault_cause,
	input  wire logic [7:0]  fault_detail,
	input  wire logic        fault_fixed,
	input  wire logic        fault_sticky,
	output logic             lamp_ready,
	output logic             lamp_error,
	output logic             lamp_port_a,
	output logic             lamp_port_b,
	output logic             lamp_write_lock,
	output logic             lamp_spindle,
	output logic             spin_request,
	output logic             retract_heads,
	output logic             online_a,
	output logic             online_b,
	output logic             drive_available,
	output logic             hold_state,
	output logic      [7:0]  status_byte15
);
	import front_panel_pkg::*;

	logic [NUM_SW-1:0]     pin_meta_q;
	logic [NUM_SW-1:0]     sw_q;
	logic [1:0]            sync_ok_q;
	logic                  btn_prev_q;
	panel_e                state_q;
	panel_e                state_d;
	logic [1:0]            ctrl_q;
	logic                  dd_prev_q;
	logic [3:0]            hidx_q;
	logic                  fault_q;
	logic [5:0]            code_q;
	logic [7:0]            detail_q;
	logic [3:0]            wptr_q;
	logic [4:0]            hcount_q;
	logic                  armed_q;
	logic [31:0]           blink_cnt_q;
	logic                  blink_q;
	logic [5:0]            lamp_q;
	logic [5:0]            lamp_d;
	logic                  dp_wr_q;
	logic [7:0]            dp_addr_q;
	logic [7:0]            hist_rdata;
	logic [NUM_CAUSES-1:0] cause;
	logic [5:0]            new_code;
	logic                  any_cause;
	logic                  btn_rise;
	logic                  clear_press;
	logic                  fault_clear;
	logic                  hist_we;
	logic                  wlock_any;
	logic                  spin_d;
	logic                  wr_ctrl;
	logic [31:0]           rd_mux;

	// two flops on every panel pin before any logic looks at it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_meta_q <= '0;
			sw_q       <= '0;
			sync_ok_q  <= 2'b00;
		end
		else
		begin
			pin_meta_q <= {port_b_switch_pin, port_a_switch_pin, write_lock_switch,
				error_button_pin, run_switch_pin};
			sw_q       <= pin_meta_q;
			sync_ok_q  <= {sync_ok_q[0], 1'b1}; // sw_q holds real pin levels once full
		end
	end

	assign btn_rise  = sw_q[SW_ERR] & ~btn_prev_q;
	assign wlock_any = sw_q[SW_WL] | ctrl_q[CTRL_LLOCK];

	// fault events: external causes plus disable bit and locked write
	assign cause = {write_attempt & wlock_any, ctrl_q[CTRL_DDIS] & ~dd_prev_q, // [RL21]
		fault_cause};
	assign any_cause = |cause;

	// most severe of simultaneous causes wins, newest event replaces old
	always_comb
	begin
		new_code = 6'h00;
		for (int i = NUM_CAUSES - 1; i >= 0; i--)
			if (cause[i])
				new_code = CAUSE_CODE[i]; // [RL13] [RL17] [RL18] [RL19] [RL20] [RL21]
	end

	// error button sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			P_NORMAL:
			begin
				if (btn_rise && fault_q)
					state_d = P_SHOW; // [RL11]
				else if (btn_rise && post_done)
					state_d = P_TEST; // [RL16]
			end
			P_SHOW:
			begin
				if (btn_rise)
					state_d = P_NORMAL; // [RL12]
			end
			P_TEST:
			begin
				if (!sw_q[SW_ERR])
					state_d = P_NORMAL; // [RL16]
			end
			default: state_d = P_NORMAL;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q    <= P_NORMAL;
			btn_prev_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			btn_prev_q <= sw_q[SW_ERR];
		end
	end

	assign clear_press = (state_q == P_SHOW) && btn_rise;
	// some conditions survive a clear press; a new event always wins
	assign fault_clear = fault_fixed | (clear_press & ~fault_sticky); // [RL10] [RL12]
	assign hist_we     = fault_q & fault_clear & ~any_cause; // [RL14]

	// fault flag, displayed code, status byte and detail for the history
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fault_q       <= 1'b0;
			code_q        <= 6'h00;
			detail_q      <= 8'h00;
			status_byte15 <= 8'h00;
			dd_prev_q     <= 1'b0;
		end
		else
		begin
			dd_prev_q <= ctrl_q[CTRL_DDIS];
			if (any_cause)
			begin
				fault_q       <= 1'b1; // [RL3]
				code_q        <= new_code; // [RL13]
				detail_q      <= fault_detail;
				status_byte15 <= {2'b00, new_code}; // [RL15]
			end
			else if (fault_clear)
				fault_q <= 1'b0; // [RL10]
		end
	end

	// history write pointer and fill count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wptr_q   <= 4'h0;
			hcount_q <= 5'h00;
		end
		else if (hist_we)
		begin
			wptr_q <= wptr_q + 4'h1; // [RL14]
			if (hcount_q != 5'(HIST_DEPTH))
				hcount_q <= hcount_q + 5'h01;
		end
	end

	history_silo u_silo (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (hist_we),
		.waddr   (wptr_q),
		.wdata   (detail_q),
		.raddr   (hidx_q),
		.rdata_q (hist_rdata)
	);

	// spin-up is armed only by a stop position or a controller command
	always_comb
	begin
		spin_d = spin_request;
		if (sw_q[SW_RUN] && armed_q)
			spin_d = 1'b1; // [RL6] [RL7]
		else if (!sw_q[SW_RUN] && !ops_pending)
			spin_d = 1'b0; // [RL6] [RL8]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			armed_q       <= 1'b0;
			spin_request  <= 1'b0;
			retract_heads <= 1'b1;
		end
		else
		begin
			// a stop seen before the syncs fill is their reset value, not the switch
			if ((sync_ok_q[1] && !sw_q[SW_RUN]) || (wr_ctrl && hwdata[CTRL_SPIN]))
				armed_q <= 1'b1; // [RL7]
			spin_request  <= spin_d;
			retract_heads <= ~spin_d; // [RL6]
		end
	end

	// blink timebase; a long count, shorten BLINK_CYC in simulation
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end
		else if (blink_cnt_q >= BLINK_CYC - 1)
		begin
			blink_cnt_q <= 32'h0;
			blink_q     <= ~blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 32'h1;
	end

	// lamp selection: test, low supply, fault code, then normal service
	always_comb
	begin
		lamp_d          = LAMPS_OFF;
		lamp_d[L_SPIN]  = spindle_turning; // [RL1]
		lamp_d[L_READY] = spindle_turning & on_cylinder & ~seeking & host_ready; // [RL2]
		lamp_d[L_ERR]   = fault_q; // [RL3]
		lamp_d[L_LOCK]  = wlock_any; // [RL4]
		lamp_d[L_A]     = sw_q[SW_PA] & ctrl_access_a; // [RL5]
		lamp_d[L_B]     = sw_q[SW_PB] & ctrl_access_b; // [RL5]
		if (state_q == P_TEST)
			lamp_d = LAMPS_ALL; // [RL16]
		else if (dc_low)
			lamp_d = LAMPS_DCLOW; // [RL22]
		else if (state_q == P_SHOW)
			lamp_d = blink_q ? (code_q | 6'h02) : LAMPS_OFF; // [RL11] [RL23]
	end

	// online and availability drop while the code is on show
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lamp_q          <= LAMPS_OFF;
			online_a        <= 1'b0;
			online_b        <= 1'b0;
			drive_available <= 1'b0;
			hold_state      <= 1'b0;
		end
		else
		begin
			lamp_q          <= lamp_d;
			online_a        <= sw_q[SW_PA] & ctrl_access_a & (state_d != P_SHOW); // [RL11]
			online_b        <= sw_q[SW_PB] & ctrl_access_b & (state_d != P_SHOW); // [RL11]
			drive_available <= (state_d != P_SHOW) & (sw_q[SW_PA] | sw_q[SW_PB]); // [RL12]
			hold_state      <= fault_q & ~fault_clear | any_cause; // [RL10]
		end
	end

	assign lamp_ready      = lamp_q[L_READY];
	assign lamp_error      = lamp_q[L_ERR];
	assign lamp_port_a     = lamp_q[L_A];
	assign lamp_port_b     = lamp_q[L_B];
	assign lamp_write_lock = lamp_q[L_LOCK];
	assign lamp_spindle    = lamp_q[L_SPIN];

	// read mux built in the address phase so data stand in the data phase
	always_comb
	begin
		rd_mux = 32'h0;
		if (haddr[31:8] == 24'h0)
		begin
			case (haddr[7:0])
				CTRL_OFF: rd_mux[1:0] = ctrl_q;
				STAT_OFF:
				begin
					rd_mux[ST_FAULT]         = fault_q;
					rd_mux[ST_SHOW]          = state_q == P_SHOW;
					rd_mux[ST_TEST]          = state_q == P_TEST;
					rd_mux[ST_SPIN]          = spin_request;
					rd_mux[ST_ARMED]         = armed_q;
					rd_mux[ST_LAMP+5:ST_LAMP] = lamp_q;
				end
				CODE_OFF: rd_mux[7:0] = status_byte15;
				HIDX_OFF:
				begin
					rd_mux[3:0]                 = hidx_q;
					rd_mux[HIDX_CNT+4:HIDX_CNT] = hcount_q;
				end
				HDAT_OFF: rd_mux[7:0] = hist_rdata;
				default:  rd_mux = 32'h0;
			endcase
		end
	end

	assign wr_ctrl = dp_wr_q && dp_addr_q == CTRL_OFF;

	// AHB-Lite slave: no wait states, always OKAY, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			dp_wr_q   <= hsel & htrans[1] & hready & hwrite & (haddr[31:8] == 24'h0);
			dp_addr_q <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// software registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q <= CTRL_RST;
			hidx_q <= 4'h0;
		end
		else if (dp_wr_q)
		begin
			if (dp_addr_q == CTRL_OFF)
				ctrl_q <= hwdata[1:0]; // [RL4] [RL21]
			if (dp_addr_q == HIDX_OFF)
				hidx_q <= hwdata[3:0];
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic pnorm;
	assign pnorm = state_q == P_NORMAL && !dc_low;

	sequence s_clear_press;
		state_q == P_SHOW ##0 btn_rise;
	endsequence

	a_spin_lamp_track: assert property (pnorm |=> lamp_spindle == $past(spindle_turning)) // [RL1]
		else $error("spindle lamp does not follow rotation");
	a_ready_seek_dark: assert property (pnorm && seeking |=> !lamp_ready) // [RL2]
		else $error("ready lamp lit while seeking");
	a_error_lamp_fault: assert property (pnorm |=> lamp_error == $past(fault_q)) // [RL3]
		else $error("error lamp differs from fault flag");
	a_lock_lamp_src: assert property (pnorm && sw_q[SW_WL] |=> lamp_write_lock) // [RL4]
		else $error("lock lamp dark under lock switch");
	a_show_offline: assert property (state_q == P_SHOW |-> !online_a && !online_b) // [RL11]
		else $error("online while fault code shown");
	a_clear_returns: assert property (s_clear_press |=> state_q == P_NORMAL && // [RL12]
		drive_available == $past(sw_q[SW_PA] | sw_q[SW_PB]))
		else $error("second press did not restore service");
	a_stop_waits_ops: assert property (spin_request && ops_pending |=> spin_request) // [RL8]
		else $error("spin dropped with operations pending");
	a_test_all_lit: assert property (state_q == P_TEST |=> lamp_q == LAMPS_ALL) // [RL16]
		else $error("lamp test not all lit");
	a_dclow_pattern: assert property (dc_low && state_q != P_TEST |=> lamp_q == LAMPS_DCLOW) // [RL22]
		else $error("low supply lamp pattern wrong");
	a_code_logged: assert property (any_cause |=> status_byte15 == {2'b00, $past(new_code)}) // [RL15]
		else $error("status byte not updated with code");
	a_hist_advance: assert property (hist_we |=> wptr_q == $past(wptr_q) + 4'h1) // [RL14]
		else $error("history pointer did not advance");
	a_show_encoding: assert property (state_q == P_SHOW && !dc_low && blink_q // [RL23]
		|=> lamp_q == ($past(code_q) | 6'h02))
		else $error("shown lamps differ from code");
endmodule

// ### tb/drive_side_model.sv
/*
  Behavioural spindle and servo of the drive mechanism.
  Assumes spin_request from the panel block on hclk.
*/
`timescale 1ns/1ps
module drive_side_model
#(
	parameter int SPIN_CYC = 10
)
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic spin_request,
	input  wire logic seek_cmd,
	output logic      spindle_turning,
	output logic      on_cylinder,
	output logic      seeking
);
	int speed_q;
	// short ramp; the bench spaces its starts itself, no motor lockout here
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			speed_q <= 0;
		else if (spin_request && speed_q < SPIN_CYC)
			speed_q <= speed_q + 1;
		else if (!spin_request && speed_q > 0)
			speed_q <= speed_q - 1;
	end
	// on cylinder only at full speed and not seeking
	assign spindle_turning = (speed_q != 0);
	assign seeking         = seek_cmd && (speed_q == SPIN_CYC);
	assign on_cylinder     = (speed_q == SPIN_CYC) && !seek_cmd;
endmodule

// ### tb/drive_front_panel_control_tb_top.sv
/*
  Self-checking bench of the front-panel control block.
  Assumes the drive_side_model partner and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/1ps
module drive_front_panel_control_tb_top;
	import front_panel_pkg::*;
	logic               hclk = 1'b0;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic               hwrite = 1'b0;
	logic [31:0]        haddr = 32'h0;
	logic [31:0]        hwdata = 32'h0;
	logic [1:0]         htrans = 2'h0;
	logic               run_sw = 1'b1;
	logic               btn = 1'b0;
	logic               wl_sw = 1'b0;
	logic               pa_sw = 1'b0;
	logic               pb_sw = 1'b0;
	logic               acc_a = 1'b0;
	logic               acc_b = 1'b0;
	logic               host_ready = 1'b0;
	logic               post_done = 1'b0;
	logic               ops = 1'b0;
	logic               dc_low = 1'b0;
	logic               wr_att = 1'b0;
	logic               fixed = 1'b0;
	logic               sticky = 1'b0;
	logic               seek_cmd = 1'b0;
	logic [NUM_EXT-1:0] cause = '0;
	logic [7:0]         detail = 8'h0;
	logic [31:0]        hrdata;
	logic               hreadyout, spin_t, on_cyl, seeking, spin_request, retract_heads;
	logic               l_rdy, l_err, l_a, l_b, l_wl, l_sp, online_a, online_b, avail;
	logic               hold_st, hresp;
	logic [7:0]         sb15;
	logic [5:0]         lamps;
	int                 errors = 0;
	int                 cmp_count = 0;
	logic [7:0]         codes [15] = '{8'h10, 8'h18, 8'h14, 8'h08, 8'h1c, 8'h0d, 8'h01,
		8'h09, 8'h05, 8'h20, 8'h28, 8'h30, 8'h38, 8'h34, 8'h3d};

	// lamps in the order of their code weights
	assign lamps = {l_sp, l_wl, l_b, l_a, l_err, l_rdy};
	// 5 ns period
	always #2.5 hclk = ~hclk;

	drive_front_panel_control #(.BLINK_CYC(4)) u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .run_switch_pin(run_sw), .error_button_pin(btn),
		.write_lock_switch(wl_sw), .port_a_switch_pin(pa_sw), .port_b_switch_pin(pb_sw),
		.spindle_turning(spin_t), .on_cylinder(on_cyl), .seeking(seeking),
		.host_ready(host_ready), .post_done(post_done), .ctrl_access_a(acc_a),
		.ctrl_access_b(acc_b), .ops_pending(ops), .dc_low(dc_low), .write_attempt(wr_att),
		.fault_cause(cause), .fault_detail(detail), .fault_fixed(fixed),
		.fault_sticky(sticky), .lamp_ready(l_rdy), .lamp_error(l_err), .lamp_port_a(l_a),
		.lamp_port_b(l_b), .lamp_write_lock(l_wl), .lamp_spindle(l_sp),
		.spin_request(spin_request), .retract_heads(retract_heads), .online_a(online_a),
		.online_b(online_b), .drive_available(avail), .hold_state(hold_st),
		.status_byte15(sb15));

	drive_side_model #(.SPIN_CYC(10)) u_mech (.hclk(hclk), .hresetn(hresetn),
		.spin_request(spin_request), .seek_cmd(seek_cmd), .spindle_turning(spin_t),
		.on_cylinder(on_cyl), .seeking(seeking));

	task automatic end_sim();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// address phase held until hready, then data phase; read data taken at its end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(nm, e, r);
	endtask

	task automatic press();
		btn <= 1'b1;
		cyc(6);
		btn <= 1'b0;
		cyc(6);
	endtask

	task automatic pulse_cause(input int i, input logic [7:0] d);
		cause <= NUM_EXT'(1) << i;
		detail <= d;
		cyc(1);
		cause <= '0;
		cyc(3);
	endtask

	task automatic pulse_fix();
		fixed <= 1'b1;
		cyc(1);
		fixed <= 1'b0;
		cyc(3);
	endtask

	task automatic t_reset();
		chk1("spin_req", 1'b0, spin_request);
		chk1("retract", 1'b1, retract_heads);
		rdc("ctrl", CTRL_OFF, 32'h0);
		rdc("status", STAT_OFF, 32'h0);
		rdc("hidx", HIDX_OFF, 32'h0);
		chk1("hresp", 1'b0, hresp);
		chk1("no_auto_spin", 1'b0, spin_request);
		wr(8'h40, 32'hffffffff);
		rdc("unmapped", 8'h40, 32'h0);
	endtask

	task automatic t_spin();
		wr(CTRL_OFF, 32'h4);
		cyc(3);
		chk1("spin_req", 1'b1, spin_request);
		chk1("retract", 1'b0, retract_heads);
		host_ready <= 1'b1;
		cyc(16);
		chk1("lamp_spin", 1'b1, l_sp);
		chk1("lamp_ready", 1'b1, l_rdy);
		seek_cmd <= 1'b1;
		cyc(3);
		chk1("lamp_ready_seek", 1'b0, l_rdy);
		seek_cmd <= 1'b0;
	endtask

	task automatic t_lamps();
		wl_sw <= 1'b1;
		cyc(6);
		chk1("lamp_lock_sw", 1'b1, l_wl);
		wl_sw <= 1'b0;
		cyc(6);
		chk1("lamp_lock_off", 1'b0, l_wl);
		wr(CTRL_OFF, 32'h1);
		cyc(3);
		chk1("lamp_lock_reg", 1'b1, l_wl);
		wr(CTRL_OFF, 32'h0);
		pa_sw <= 1'b1;
		acc_a <= 1'b1;
		cyc(6);
		chk1("online_a", 1'b1, online_a);
		chk1("lamp_a", 1'b1, l_a);
	endtask

	task automatic t_codes();
		for (int i = 0; i < 15; i++)
		begin
			pulse_cause(i, 8'(i));
			chk("code", {24'h0, codes[i]}, {24'h0, sb15});
			chk1("lamp_err", 1'b1, l_err);
			pulse_fix();
			chk1("lamp_err_fixed", 1'b0, l_err);
		end
		rdc("hist_count", HIDX_OFF, 32'h0f00);
	endtask

	task automatic t_show();
		logic [5:0] o;
		logic [5:0] a;
		pulse_cause(0, 8'h11);
		pulse_cause(3, 8'h5a);
		chk("recent", 32'h08, {24'h0, sb15});
		press();
		chk1("offline", 1'b0, online_a);
		o = 6'h0;
		a = 6'h3f;
		// over a full blink period the code lamps must both light and go dark
		repeat (8)
		begin
			@(posedge hclk);
			o = o | lamps;
			a = a & lamps;
		end
		chk("blink_on", 32'h0a, {26'h0, o});
		chk("blink_off", 32'h0, {26'h0, a});
		chk1("still_off", 1'b0, online_a);
		press();
		chk1("lamp_err_clr", 1'b0, l_err);
		chk1("available", 1'b1, avail);
		rdc("hist_full", HIDX_OFF, 32'h1000);
		wr(HIDX_OFF, 32'h0f);
		rdc("hidx_set", HIDX_OFF, 32'h100f);
		rdc("hist_last", HDAT_OFF, 32'h5a);
	endtask

	task automatic t_misc();
		wl_sw <= 1'b1;
		cyc(6);
		wr_att <= 1'b1;
		cyc(1);
		wr_att <= 1'b0;
		cyc(3);
		chk("locked_write", 32'h2c, {24'h0, sb15});
		pulse_fix();
		wl_sw <= 1'b0;
		wr(CTRL_OFF, 32'h2);
		cyc(3);
		chk("disabled", 32'h24, {24'h0, sb15});
		pulse_fix();
		wr(CTRL_OFF, 32'h0);
		rdc("hist_sat", HIDX_OFF, 32'h100f);
	endtask

	// a condition that survives the clear press, seen through port b
	task automatic t_sticky();
		pb_sw <= 1'b1;
		acc_b <= 1'b1;
		sticky <= 1'b1;
		cyc(6);
		chk1("online_b", 1'b1, online_b);
		chk1("lamp_b", 1'b1, l_b);
		pulse_cause(5, 8'h33);
		chk("servo_lock", 32'h0d, {24'h0, sb15});
		chk1("held", 1'b1, hold_st);
		press();
		chk1("offline_b", 1'b0, online_b);
		press();
		chk1("sticky_err", 1'b1, l_err);
		chk1("online_b_back", 1'b1, online_b);
		sticky <= 1'b0;
		pulse_fix();
		chk1("unheld", 1'b0, hold_st);
	endtask

	task automatic t_test_dc();
		post_done <= 1'b1;
		btn <= 1'b1;
		cyc(6);
		chk("lamp_test", 32'h3f, {26'h0, lamps});
		btn <= 1'b0;
		cyc(6);
		chk1("test_back", 1'b0, l_err);
		chk1("test_back_sp", 1'b1, l_sp);
		dc_low <= 1'b1;
		cyc(3);
		chk("dc_low", 32'h3d, {26'h0, lamps});
		dc_low <= 1'b0;
	endtask

	task automatic t_stop();
		ops <= 1'b1;
		run_sw <= 1'b0;
		cyc(8);
		chk1("stop_wait", 1'b1, spin_request);
		ops <= 1'b0;
		cyc(4);
		chk1("stopped", 1'b0, spin_request);
		chk1("retracted", 1'b1, retract_heads);
		cyc(16);
		chk1("lamp_spin_off", 1'b0, l_sp);
	endtask

	// watchdog well beyond the roughly 360 cycles the run needs
	initial
	begin
		cyc(5000);
		errors++;
		end_sim();
	end

	// main sequence
	initial
	begin
		cyc(20);
		hresetn <= 1'b1;
		cyc(1);
		t_reset();
		t_spin();
		t_lamps();
		t_codes();
		t_show();
		t_misc();
		t_sticky();
		t_test_dc();
		t_stop();
		end_sim();
	end
endmodule
